// file: vbs_pkg.sv
// Constants, register map and types for the bit sync and coding sublayer
package vbs_pkg;
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_DIV  = 8'h04;
  localparam logic [7:0] A_IST  = 8'h08;
  localparam logic [7:0] A_IEN  = 8'h0c;
  localparam logic [7:0] A_ICLR = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  // Control fields
  localparam int CTRL_EM    = 0;
  localparam int CTRL_CORR  = 1;
  localparam int CTRL_FORCE = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // Event bits
  localparam int EV_COL  = 0;
  localparam int EV_BERR = 1;
  localparam int EV_CERR = 2;
  localparam int EV_BIT  = 3;
  localparam int EV_W    = 4;
  // Divider: system clocks per corrected period
  localparam logic [7:0] DIV_RST = 8'h0c;
  localparam logic [7:0] DIV_MIN = 8'h02;
  // Synchronization counter points
  localparam logic [5:0] CNT_FIRST   = 6'h01;
  localparam logic [5:0] LOAD_FIRST  = 6'h02;
  localparam logic [5:0] LOAD_SECOND = 6'h12;
  localparam logic [5:0] SMP_FIRST   = 6'h0b;
  localparam logic [5:0] SMP_SECOND  = 6'h1b;
  localparam logic [5:0] TX_FIRST    = 6'h10;
  localparam logic [5:0] TX_SECOND   = 6'h20;
  localparam logic [5:0] SYM_RISE    = 6'h01;
  localparam logic [5:0] SYM_FALL    = 6'h03;
  // Tick clock periods and bit pattern
  localparam logic [5:0] TICK_EM   = 6'h10;
  localparam logic [5:0] TICK_ML   = 6'h20;
  localparam logic [1:0] MAN_SLOT  = 2'h3;
  // Idle before a frame, in corrected periods
  localparam logic [7:0] IDLE_HCOR = 8'h80;
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SEND} vbs_tx_e;
endpackage

// file: vbs_sync_coder.sv
// Encoding, decoding and bit synchronization sublayer with APB registers
// Operation
// - Receive from comparator, drive line driver input
// - Output forcing receive comparators recessive
// - Derive corrected, symbol and tick clocks
// - Correction measures frame start as reference
// - Resync only on received line edges
// - Own preamble sending disables resynchronization
// - Load counter at t+1: 2 or 18
// - Collision and slot sampled at 11
// - Bit sampled at 11 NRZ, 27 Manchester
// - Transmit transitions at 16 and 32
// - Device captures MAC inputs on symbol fall
// - Signals valid half period before capture
// - 128 idle periods before frame start
// - Error signals outside symbol clock timing
// - Tick every 16 or 32 periods
// - Enhanced code: Manchester bit every fourth
`timescale 1ns/1ps
`default_nettype none
module vbs_sync_coder
  import vbs_pkg::*;
#(
  parameter int          PRE_BITS  = 4,
  parameter int          SOF_SHIFT = 5,
  parameter logic [7:0]  ERR_HCOR  = 8'hc8
) (
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             irq_o,
  input  wire logic        line_rx_in_i,
  output logic             driver_level_in_o,
  output logic             comp_force_o,
  input  wire logic        mac_req_i,
  input  wire logic        mac_bit_i,
  input  wire logic        mac_inhibit_i,
  output logic             hcor_o,
  output logic             hsymb_o,
  output logic             hpl_o,
  output logic             rx_bit_o,
  output logic             collision_o,
  output logic             bus_busy_o,
  output logic             bus_err_o,
  output logic             clk_err_o
);
  logic [2:0]      ctrl;
  logic [7:0]      div_reg;
  logic [EV_W-1:0] ist;
  logic [EV_W-1:0] ien;
  logic            rx_m;
  logic            rx_s;
  logic            rx_d;
  logic            rx_prev;
  logic [7:0]      pre_cnt;
  logic [5:0]      scnt;
  logic [1:0]      bit_idx;
  logic [5:0]      hpl_cnt;
  logic            pend;
  logic            pend_second;
  logic [7:0]      idle_cnt;
  logic [7:0]      dom_cnt;
  logic [15:0]     meas;
  logic            armed;
  logic [7:0]      div_cor;
  logic            cor_valid;
  logic            cur_bit;
  logic            next_bit;
  logic            req_q;
  logic [3:0]      pre_left;
  vbs_tx_e         tx_state;

  // Divider selection and corrected period tick
  wire       code_em   = ctrl[CTRL_EM];
  wire [7:0] div_eff   = (ctrl[CTRL_CORR] && cor_valid) ? div_cor : div_reg;
  wire       hcor_tick = (pre_cnt >= div_eff - 8'h01);
  wire [7:0] half_div  = {1'b0, div_eff[7:1]};

  // Bit structure decode
  wire       man_bit   = !code_em || (bit_idx == MAN_SLOT);
  wire       in_second = man_bit && (scnt > TX_FIRST);
  wire [5:0] bit_len   = man_bit ? TX_SECOND : TX_FIRST;
  wire       bit_end   = (scnt >= bit_len);
  wire [5:0] smp_bit   = man_bit ? SMP_SECOND : SMP_FIRST;
  wire       sending   = (tx_state == TX_SEND);
  wire       preamble  = sending && (pre_left != 4'h0);
  wire       rx_edge   = (rx_s != rx_prev);
  wire       resync_ok = !preamble;
  wire [5:0] tick_len  = code_em ? TICK_EM : TICK_ML;
  wire       idle_full = (idle_cnt == IDLE_HCOR);
  wire       go_send   = hcor_tick && (tx_state == TX_WAIT) && idle_full;
  wire       at_sym_r  = (scnt == smp_bit + SYM_RISE);
  wire       at_sym_f  = (scnt == smp_bit + SYM_FALL);

  // APB decode
  wire        acc     = psel_i && penable_i;
  wire        wr_go   = acc && pready_o && pwrite_i;
  wire        rd_hit  = (paddr_i == A_CTRL) || (paddr_i == A_DIV) || (paddr_i == A_IST) ||
                        (paddr_i == A_IEN) || (paddr_i == A_STAT);
  wire        wr_hit  = rd_hit && (paddr_i != A_IST) && (paddr_i != A_STAT) || (paddr_i == A_ICLR);
  wire        bad     = pwrite_i ? !wr_hit : !rd_hit;
  wire [31:0] stat_w  = {14'h0, tx_state, div_eff, bus_busy_o, rx_bit_o, scnt};
  wire [31:0] rd_mux  = (paddr_i == A_CTRL) ? {29'h0, ctrl} :
                        (paddr_i == A_DIV)  ? {24'h0, div_reg} :
                        (paddr_i == A_IST)  ? {28'h0, ist} :
                        (paddr_i == A_IEN)  ? {28'h0, ien} :
                        (paddr_i == A_STAT) ? stat_w : 32'h0;
  wire [EV_W-1:0] clr = (wr_go && paddr_i == A_ICLR) ? pwdata_i[EV_W-1:0] : '0;
  wire mode_chg = wr_go && (paddr_i == A_CTRL) && (pwdata_i[CTRL_EM] != code_em); // Code switch restarts timing
  wire restart  = go_send || mode_chg;

  // Events feeding the sticky status
  wire col_ev  = hcor_tick && sending && !in_second && (scnt == SMP_FIRST) && (rx_s != driver_level_in_o);
  wire bit_ev  = hcor_tick && (scnt == smp_bit);
  wire berr_ev = hcor_tick && !rx_s && (dom_cnt == ERR_HCOR);
  wire meas_end = armed && rx_s && !rx_d;
  wire [7:0] meas_div = meas[SOF_SHIFT +: 8];
  wire cerr_ev = (meas_end && meas_div < DIV_MIN) || (armed && !rx_s && meas == 16'hffff);
  wire [EV_W-1:0] ev = {bit_ev, cerr_ev, berr_ev, col_ev};

  // APB handshake, one wait state
  always_ff @(posedge clock_i or negedge resetn_i)
    if (!resetn_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0;
    end
    else
    begin
      pready_o  <= acc && !pready_o;
      pslverr_o <= acc && !pready_o && bad;
      prdata_o  <= (acc && !pready_o && !pwrite_i) ? rd_mux : 32'h0;
    end

  // Software registers, set wins over clear
  always_ff @(posedge clock_i or negedge resetn_i)
    if (!resetn_i)
    begin
      ctrl    <= CTRL_RST;
      div_reg <= DIV_RST;
      ien     <= '0;
      ist     <= '0;
      irq_o   <= 1'b0;
    end
    else
    begin
      if (wr_go && paddr_i == A_CTRL) ctrl <= pwdata_i[2:0];
      if (wr_go && paddr_i == A_DIV && pwdata_i[7:0] >= DIV_MIN) div_reg <= pwdata_i[7:0];
      if (wr_go && paddr_i == A_IEN) ien <= pwdata_i[EV_W-1:0];
      ist   <= (ist & ~clr) | ev;
      irq_o <= |(ist & ien);
    end

  // Line input synchroniser
  always_ff @(posedge clock_i or negedge resetn_i)
    if (!resetn_i)
    begin
      rx_m <= 1'b1;
      rx_s <= 1'b1;
      rx_d <= 1'b1;
    end
    else
    begin
      rx_m <= line_rx_in_i;
      rx_s <= rx_m;
      rx_d <= rx_s;
    end

  // Corrected clock divider and tick clock
  always_ff @(posedge clock_i or negedge resetn_i)
    if (!resetn_i)
    begin
      pre_cnt <= 8'h0;
      hpl_cnt <= 6'h0;
      hcor_o  <= 1'b0;
      hpl_o   <= 1'b0;
    end
    else
    begin
      pre_cnt <= hcor_tick ? 8'h0 : pre_cnt + 8'h01;
      if (mode_chg) hpl_cnt <= 6'h0;
      else if (hcor_tick) hpl_cnt <= (hpl_cnt >= tick_len - 6'h01) ? 6'h0 : hpl_cnt + 6'h01;
      hcor_o  <= (pre_cnt < half_div);
      hpl_o   <= (hpl_cnt < {1'b0, tick_len[5:1]});
    end

  // Start-of-frame measurement for the corrected clock
  always_ff @(posedge clock_i or negedge resetn_i)
    if (!resetn_i)
    begin
      meas      <= 16'h0;
      armed     <= 1'b0;
      div_cor   <= DIV_RST;
      cor_valid <= 1'b0;
    end
    else
    begin
      if (idle_full && rx_s) armed <= ctrl[CTRL_CORR];
      else if (meas_end || cerr_ev) armed <= 1'b0;
      meas <= (armed && !rx_s) ? meas + 16'h1 : (rx_s ? 16'h0 : meas);
      if (meas_end && meas_div >= DIV_MIN)
      begin
        div_cor   <= meas_div;
        cor_valid <= 1'b1;
      end
    end

  // Synchronization counter with edge resync
  always_ff @(posedge clock_i or negedge resetn_i)
    if (!resetn_i)
    begin
      scnt        <= CNT_FIRST;
      bit_idx     <= 2'h0;
      rx_prev     <= 1'b1;
      pend        <= 1'b0;
      pend_second <= 1'b0;
    end
    else if (restart)
    begin
      scnt    <= CNT_FIRST;
      bit_idx <= 2'h0;
      pend    <= 1'b0;
      rx_prev <= rx_s;
    end
    else if (hcor_tick)
    begin
      rx_prev     <= rx_s;
      pend        <= rx_edge && resync_ok;
      pend_second <= in_second && !bit_end;
      if (pend) scnt <= pend_second ? LOAD_SECOND : LOAD_FIRST;
      else if (bit_end) scnt <= CNT_FIRST;
      else scnt <= scnt + 6'h01;
      if (bit_end && !pend) bit_idx <= bit_idx + 2'h1;
    end

  // Idle and dominant run counters
  always_ff @(posedge clock_i or negedge resetn_i)
    if (!resetn_i)
    begin
      idle_cnt   <= 8'h0;
      dom_cnt    <= 8'h0;
      bus_busy_o <= 1'b1;
    end
    else if (hcor_tick)
    begin
      idle_cnt   <= !rx_s ? 8'h0 : (idle_full ? idle_cnt : idle_cnt + 8'h01);
      dom_cnt    <= rx_s ? 8'h0 : ((dom_cnt == ERR_HCOR) ? dom_cnt : dom_cnt + 8'h01);
      bus_busy_o <= !(idle_full && rx_s);
    end

  // Receive sampling, symbol clock and MAC capture
  always_ff @(posedge clock_i or negedge resetn_i)
    if (!resetn_i)
    begin
      rx_bit_o    <= 1'b1;
      collision_o <= 1'b0;
      hsymb_o     <= 1'b0;
      next_bit    <= 1'b1;
      req_q       <= 1'b0;
    end
    else if (hcor_tick)
    begin
      if (!in_second && scnt == SMP_FIRST) collision_o <= sending && (rx_s != driver_level_in_o);
      if (scnt == smp_bit) rx_bit_o <= man_bit ? !rx_s : rx_s;
      if (at_sym_r) hsymb_o <= 1'b1;
      else if (at_sym_f) hsymb_o <= 1'b0;
      if (at_sym_f)
      begin
        next_bit <= mac_bit_i;
        req_q    <= mac_req_i;
      end
    end

  // Transmit sequencer and line driver
  always_ff @(posedge clock_i or negedge resetn_i)
    if (!resetn_i)
    begin
      tx_state          <= TX_IDLE;
      driver_level_in_o <= 1'b1;
      cur_bit           <= 1'b1;
      pre_left          <= 4'h0;
    end
    else
    begin
      case (tx_state)
        TX_IDLE:
          if (mac_req_i && !mac_inhibit_i) tx_state <= TX_WAIT;
        TX_WAIT:
          if (go_send)
          begin
            tx_state          <= TX_SEND;
            cur_bit           <= mac_bit_i;
            driver_level_in_o <= mac_bit_i;
            pre_left          <= 4'(PRE_BITS);
          end
        TX_SEND:
          if (mac_inhibit_i)
          begin
            tx_state          <= TX_IDLE;
            driver_level_in_o <= 1'b1;
          end
          else if (hcor_tick && bit_end)
          begin
            tx_state          <= req_q ? TX_SEND : TX_IDLE;
            cur_bit           <= next_bit;
            driver_level_in_o <= req_q ? next_bit : 1'b1;
            if (pre_left != 4'h0) pre_left <= pre_left - 4'h1;
          end
          else if (hcor_tick && man_bit && scnt == TX_FIRST)
            driver_level_in_o <= !cur_bit;
        default:
          tx_state <= TX_IDLE;
      endcase
    end

  // Comparator force and error outputs
  always_ff @(posedge clock_i or negedge resetn_i)
    if (!resetn_i)
    begin
      comp_force_o <= 1'b0;
      bus_err_o    <= 1'b0;
      clk_err_o    <= 1'b0;
    end
    else
    begin
      comp_force_o <= ctrl[CTRL_FORCE];
      bus_err_o    <= ist[EV_BERR];
      clk_err_o    <= ist[EV_CERR];
    end

  // Checks
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  AST_LOAD_FIRST: assert property (hcor_tick && pend && !pend_second && !restart |=> scnt == 6'h02)
    else $error("resync did not load 2");
  AST_LOAD_SECOND: assert property (hcor_tick && pend && pend_second && !restart |=> scnt == 6'h12)
    else $error("resync did not load 18");
  AST_NO_PREAMBLE_SYNC: assert property (hcor_tick && preamble && !restart |=> !pend)
    else $error("resync armed during own preamble");
  AST_COLLISION: assert property (col_ev |=> collision_o && ist[EV_COL])
    else $error("collision not flagged");
  AST_BIT_MAN: assert property (hcor_tick && man_bit && scnt == 6'h1b |=> rx_bit_o == !$past(rx_s))
    else $error("manchester bit sampled wrong");
  AST_TX_MID: assert property (sending && !mac_inhibit_i && hcor_tick && man_bit && scnt == 6'h10
                               |=> driver_level_in_o == !cur_bit)
    else $error("mid-bit transition missing");
  AST_IDLE_BEFORE: assert property ($rose(sending) |-> $past(idle_cnt) == 8'h80)
    else $error("frame started without idle");
  AST_SCNT_SPAN: assert property (scnt >= 6'h01 && scnt <= 6'h20 && (code_em && !man_bit -> scnt <= 6'h10))
    else $error("sync counter out of span");
  AST_HSYMB_RISE: assert property ($rose(hsymb_o) |-> $past(scnt) == (man_bit ? 6'h1c : 6'h0c))
    else $error("symbol clock not after sampling point");
  AST_HPL_SPAN: assert property (hpl_cnt < (code_em ? 6'h10 : 6'h20))
    else $error("tick counter over period");
endmodule
`default_nettype wire

// file: vbs_line_model.sv
// Line transceiver model: loopback bus with a stuck-dominant fault
`timescale 1ns/1ps
`default_nettype none
module vbs_line_model (
  input  wire logic driver_level_in_i,
  input  wire logic comp_force_i,
  input  wire logic hold_dom_i,
  output logic      line_o
);
  // Comparator output, forced recessive or wired-and of the bus
  assign line_o = comp_force_i | (driver_level_in_i & ~hold_dom_i);
endmodule
`default_nettype wire

// file: vbs_sync_coder_tb.sv
// Self-checking testbench for the sync and coding sublayer
`timescale 1ns/1ps
`default_nettype none
module vbs_sync_coder_tb;
  import vbs_pkg::*;
  logic             clock_i, resetn_i, psel, penable, pwrite, mac_req, mac_bit, mac_inh, hold_dom, err;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, rd;
  wire logic [31:0] prdata;
  wire logic        pready, pslverr, irq, line, drv, frc, hcor, hsymb, hpl, rxb, col, busy, berr, cerr;
  int               error_cnt = 0;
  int               cmp_count = 0;
  // Observed outputs: 0 force, 1 rx bit, 2 driver, 3 busy, 4 bus err, 5 irq, 6 hsymb, 7 collision, 8 clk err
  wire logic [8:0]  obs = {cerr, col, hsymb, irq, berr, busy, drv, rxb, frc};
  wire logic [1:0]  clks = {hpl, hcor};

  vbs_sync_coder vbs_sync_coder_inst (.clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq), .line_rx_in_i(line), .driver_level_in_o(drv),
    .comp_force_o(frc), .mac_req_i(mac_req), .mac_bit_i(mac_bit), .mac_inhibit_i(mac_inh),
    .hcor_o(hcor), .hsymb_o(hsymb), .hpl_o(hpl), .rx_bit_o(rxb), .collision_o(col),
    .bus_busy_o(busy), .bus_err_o(berr), .clk_err_o(cerr));
  vbs_line_model vbs_line_model_inst (.driver_level_in_i(drv), .comp_force_i(frc),
    .hold_dom_i(hold_dom), .line_o(line));

  task automatic end_sim;
    if (error_cnt == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("mismatch %s exp %h got %h", nm, exp, got);
      error_cnt++;
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock_i);
    penable <= 1'b1;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("apb wait", 32'h0, {31'h0, n >= 20});
    if (n >= 20) end_sim;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk("write err", 32'h0, {31'h0, err});
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd & m);
  endtask
  task automatic wait_for(input int s, input logic v, input int lim);
    int n;
    n = 0;
    while (obs[s] !== v && n < lim)
    begin
      @(posedge clock_i);
      n++;
    end
    chk("output level", {31'h0, v}, {31'h0, obs[s]});
    if (obs[s] !== v) end_sim;
  endtask
  // System clocks from one rise of a clock output to the next
  task automatic period(input int s, input int exp);
    int n;
    int t;
    t = 0;
    for (int k = 0; k < 4; k++)
    begin
      n = 0;
      while (clks[s] !== k[0] && n < 300)
      begin
        @(posedge clock_i);
        n++;
      end
      if (k > 1) t += n;
    end
    chk("clock period", exp, t);
  endtask

  task automatic t_regs;
    rdc("ctrl rst", A_CTRL, 32'hffffffff, 32'h0);
    rdc("div rst", A_DIV, 32'hff, {24'h0, DIV_RST});
    rdc("ist rst", A_IST, 32'hffffffff, 32'h0);
    rdc("ien rst", A_IEN, 32'hffffffff, 32'h0);
    // Refused accesses: write status, write ist, read clear, unmapped
    for (int k = 0; k < 4; k++)
    begin
      apb(k < 2, k == 0 ? A_IST : k == 1 ? A_STAT : k == 2 ? A_ICLR : 8'h18, 32'hff);
      chk("refused err", 32'h1, {31'h0, err});
      chk("refused data", 32'h0, rd);
    end
  endtask
  task automatic t_clocks;
    wr(A_DIV, 32'h2);
    wr(A_DIV, 32'h1);
    rdc("div min", A_DIV, 32'hff, 32'h2);
    period(0, 2);
    wr(A_CTRL, 32'h1);
    period(1, 32);
    wr(A_CTRL, 32'h0);
    period(1, 64);
  endtask
  task automatic t_force;
    wr(A_CTRL, 32'h4);
    wait_for(0, 1'b1, 3);
    wr(A_CTRL, 32'h0);
    wait_for(0, 1'b0, 3);
  endtask
  task automatic t_berr;
    hold_dom <= 1'b1;
    repeat (380) @(posedge clock_i);
    chk("bus err early", 32'h0, {31'h0, berr});
    wait_for(4, 1'b1, 100);
    rdc("ist berr", A_IST, 32'h2, 32'h2);
    wr(A_IEN, 32'h2);
    wait_for(5, 1'b1, 3);
    wr(A_IEN, 32'h0);
    wait_for(5, 1'b0, 3);
    hold_dom <= 1'b0;
    repeat (240) @(posedge clock_i);
    chk("busy early", 32'h1, {31'h0, busy});
    wait_for(3, 1'b0, 80);
    wr(A_ICLR, 32'h2);
    rdc("ist clear", A_IST, 32'h2, 32'h0);
  endtask
  task automatic t_send;
    int z;
    z = 0;
    wr(A_IEN, 32'h8);
    mac_bit <= 1'b0;
    mac_req <= 1'b1;
    wait_for(2, 1'b0, 600);
    wait_for(2, 1'b1, 40);
    wait_for(6, 1'b1, 40);
    chk("rx bit", 32'h0, {31'h0, rxb});
    chk("collision", 32'h0, {31'h0, col});
    wait_for(5, 1'b1, 5);
    // Recessive bit against a held-dominant line
    mac_bit <= 1'b1;
    hold_dom <= 1'b1;
    wait_for(7, 1'b1, 200);
    rdc("ist col", A_IST, 32'h1, 32'h1);
    hold_dom <= 1'b0;
    mac_inh <= 1'b1;
    wait_for(2, 1'b1, 40);
    repeat (100)
    begin
      @(posedge clock_i);
      z += (drv !== 1'b1);
    end
    chk("inhibit", 32'h0, z);
    mac_req <= 1'b0;
    mac_inh <= 1'b0;
  endtask
  task automatic t_corr;
    wr(A_CTRL, 32'h2);
    wait_for(3, 1'b0, 400);
    // Short low run: measured divider below minimum
    hold_dom <= 1'b1;
    repeat (20) @(posedge clock_i);
    hold_dom <= 1'b0;
    wait_for(8, 1'b1, 10);
    wr(A_ICLR, 32'h4);
    wait_for(8, 1'b0, 5);
    // Low run of 320 clocks gives divider 10
    wait_for(3, 1'b0, 400);
    hold_dom <= 1'b1;
    repeat (320) @(posedge clock_i);
    hold_dom <= 1'b0;
    repeat (5) @(posedge clock_i);
    rdc("corr div", A_STAT, 32'hff00, 32'h0a00);
    period(0, 10);
  endtask

  // Clock generator
  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  // Main sequence
  initial
  begin
    resetn_i = 1'b0;
    {psel, penable, pwrite, mac_req, mac_bit, mac_inh, hold_dom} = 7'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (3) @(posedge clock_i);
    chk("reset outs", 32'h0e, {23'h0, obs});
    resetn_i <= 1'b1;
    t_regs;
    t_clocks;
    t_force;
    t_berr;
    t_send;
    t_corr;
    end_sim;
  end
endmodule
`default_nettype wire
